// ==== src/ieg_defs.vh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef IEG_DEFS_VH
`define IEG_DEFS_VH

// Printed offsets are not multiples of four, so they are word indices.
`define IEG_IDX_REQ 10'h00FD
`define IEG_IDX_EN 10'h00FF
// Extra registers for the block's own status, mask and gated requests.
`define IEG_IDX_IRQ_STAT 10'h0100
`define IEG_IDX_IRQ_MASK 10'h0101
`define IEG_IDX_PEND 10'h0102

`define IEG_ADDR_W 12

`define IEG_BIT_EXT_A 0
`define IEG_BIT_FIX1 1
`define IEG_BIT_SERIAL 2
`define IEG_BIT_TICK 3
`define IEG_BIT_EXT_B 4
`define IEG_BIT_TWOWIRE 5
`define IEG_BIT_TIMER 6
`define IEG_BIT_TSEL 7

`define IEG_EN_RESET 8'h00
`define IEG_REQ_RESET 8'h00
`define IEG_REQ_MASK 8'h7D
`define IEG_STAT_RESET 8'h00
`define IEG_MASK_RESET 8'h00

// Main clock divider for the periodic tick.
`define IEG_TICK_DIV 4096
`define IEG_TICK_W 12

`endif

// ==== src/ieg_top.v ====
// Second interrupt enable group with request flags and an APB slave.
// Function
// [RULE1] Enable bit 0 gates the first external pin interrupt, resets to 0.
// [RULE2] Software keeps enable bit 1 at 0; it is stored and has no effect.
// [RULE3] Enable bit 2 gates the serial interrupt and resets to 0.
// [RULE4] Enable bit 3 gates the main clock divided by 4096 tick.
// [RULE5] Enable bit 4 gates the second external pin interrupt.
// [RULE6] Enable bit 5 gates the two-wire interface interrupt.
// [RULE7] Enable bit 6 gates the shared timer interrupt.
// [RULE8] Enable bit 7 picks timer 5 (0) or timer 6 (1) overflow as source.
// [RULE9] The request register holds flags at the same bit positions.
// [RULE10] Hardware sets flags; writing 0 clears one, writing 1 keeps it.
// [RULE11] A source is raised to the core only while flag and enable are 1; irq is raised from status and irq_mask, ignoring both.
//
// Design decision made here: the APB slave port.
`include "ieg_defs.vh"

module ieg_top (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`IEG_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // External pins, asynchronous.
  input wire ext_irq_pin_a,
  input wire ext_irq_pin_b,
  // Same-clock event pulses from peripherals.
  input wire serial_event,
  input wire twowire_event,
  input wire timer5_overflow,
  input wire timer6_overflow,
  // Towards the core.
  output reg [7:0] core_irq_request,
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////
  // Register storage.
  reg [7:0] interrupt_enable_two;
  reg [7:0] interrupt_request_two;
  reg [7:0] irq_status;
  reg [7:0] irq_mask;
  reg [`IEG_TICK_W-1:0] tick_count;
  reg [7:0] next_request;
  reg [7:0] next_status;
  reg [31:0] next_rdata;
  reg next_slverr;

  // Pin conditioning.
  wire [1:0] pin_raw;
  wire [1:0] pin_rise;

  // Sources, gating and bus decode.
  wire [7:0] events;
  wire [7:0] req_and_en;
  wire [7:0] gated;
  wire [7:0] wdata;
  wire [7:0] req_clear;
  wire [7:0] stat_clear;
  wire tick_event;
  wire timer_event;
  wire setup;
  wire access;
  wire wr;
  wire hit_req;
  wire hit_en;
  wire hit_stat;
  wire hit_mask;
  wire hit_pend;
  wire hit_any;

  genvar p;

  ////////////////////////////////////////////////////////////////////////
  // Registers are whole aligned words; a set low address bit is refused.
  function sel_reg;
    input [`IEG_ADDR_W-1:0] addr;
    input [`IEG_ADDR_W-3:0] idx;
    begin
      sel_reg = (addr[1:0] == 2'b00) &&
        (addr[`IEG_ADDR_W-1:2] == idx);
    end
  endfunction

  // Shared by request and status: clear first, then a new event wins.
  function [7:0] flag_update;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      flag_update = (cur & ~clr) | set;
    end
  endfunction

  // Zero-extends a byte register to the bus width.
  function [31:0] word_of;
    input [7:0] val;
    begin
      word_of = {24'h00_0000, val};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB decode.
  assign setup = psel && !penable;
  assign access = psel && penable;
  // A write lands only at the edge where the slave shows ready, so a
  // master that stretches the access phase cannot write twice.
  assign wr = access && pready && pwrite;
  assign wdata = pwdata[7:0];

  assign hit_req = sel_reg(paddr, `IEG_IDX_REQ);
  assign hit_en = sel_reg(paddr, `IEG_IDX_EN);
  assign hit_stat = sel_reg(paddr, `IEG_IDX_IRQ_STAT);
  assign hit_mask = sel_reg(paddr, `IEG_IDX_IRQ_MASK);
  assign hit_pend = sel_reg(paddr, `IEG_IDX_PEND);
  assign hit_any = hit_req || hit_en || hit_stat || hit_mask || hit_pend;

  ////////////////////////////////////////////////////////////////////////
  // Three sync stages and a level flip-flop per pin; a level change counts only once the second
  // and third stages agree, which drops a one-cycle glitch.
  assign pin_raw = {ext_irq_pin_b, ext_irq_pin_a};

  generate
    for (p = 0; p < 2; p = p + 1) begin : g_pin
      reg [2:0] sync;
      reg level;
      wire agree;
      assign agree = (sync[2] == sync[1]);
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync <= 3'h0;
          level <= 1'b0;
        end else begin
          sync <= {sync[1:0], pin_raw[p]};
          if (agree) begin
            level <= sync[2];
          end
        end
      end
      // The filtered level resets low like an idle pin, so no false
      // edge follows reset.
      assign pin_rise[p] = agree && sync[2] && !level;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // [RULE4] Divide-by-4096 tick.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_count <= {`IEG_TICK_W{1'b0}};
    end else begin
      tick_count <= tick_count + 1'b1;
    end
  end

  // The divider runs free from reset and software cannot restart it, so
  // the first tick after an enable may come early.
  assign tick_event = (tick_count == {`IEG_TICK_W{1'b1}});

  // [RULE8] Shared timer source select.
  assign timer_event = interrupt_enable_two[`IEG_BIT_TSEL] ?
    timer6_overflow : timer5_overflow;

  ////////////////////////////////////////////////////////////////////////
  // Each cycle that a same-clock input is high is one event, so a held
  // level keeps its flag set, since the event wins over a software clear.
  // [RULE9] Request flag positions.
  assign events[`IEG_BIT_EXT_A] = pin_rise[0];
  assign events[`IEG_BIT_FIX1] = 1'b0;
  assign events[`IEG_BIT_SERIAL] = serial_event;
  assign events[`IEG_BIT_TICK] = tick_event;
  assign events[`IEG_BIT_EXT_B] = pin_rise[1];
  assign events[`IEG_BIT_TWOWIRE] = twowire_event;
  assign events[`IEG_BIT_TIMER] = timer_event;
  // Bit 7 is the source select, never a request.
  assign events[`IEG_BIT_TSEL] = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // [RULE10] Zero clears.
  assign req_clear = (wr && hit_req) ? ~wdata : 8'h00;
  // Status bits are write-one-to-clear.
  assign stat_clear = (wr && hit_stat) ? wdata : 8'h00;

  // [RULE10] Set wins over clear.
  always @* begin
    next_request = flag_update(interrupt_request_two, events, req_clear) &
      `IEG_REQ_MASK;
  end

  // Status takes raw events, so software sees a source even when it is
  // gated off from the core.
  always @* begin
    next_status = flag_update(irq_status, events, stat_clear);
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable bits gate only the path to the core; flags keep collecting
  // while disabled, so a late enable raises an old request at once.
  // [RULE11] Flag and enable both required.
  assign req_and_en = interrupt_request_two & interrupt_enable_two;

  // [RULE1] Pin a gate.
  assign gated[`IEG_BIT_EXT_A] = req_and_en[`IEG_BIT_EXT_A];
  // Bit one has no source behind it.
  assign gated[`IEG_BIT_FIX1] = 1'b0;
  // [RULE3] Serial gate.
  assign gated[`IEG_BIT_SERIAL] = req_and_en[`IEG_BIT_SERIAL];
  // [RULE4] Tick gate.
  assign gated[`IEG_BIT_TICK] = req_and_en[`IEG_BIT_TICK];
  // [RULE5] Pin b gate.
  assign gated[`IEG_BIT_EXT_B] = req_and_en[`IEG_BIT_EXT_B];
  // [RULE6] Two-wire gate.
  assign gated[`IEG_BIT_TWOWIRE] = req_and_en[`IEG_BIT_TWOWIRE];
  // [RULE7] Timer gate.
  assign gated[`IEG_BIT_TIMER] = req_and_en[`IEG_BIT_TIMER];
  // Bit 7 selects a source and never raises anything.
  assign gated[`IEG_BIT_TSEL] = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Request flags; bits 1 and 7 stay zero through the request mask.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_request_two <= `IEG_REQ_RESET;
    end else begin
      interrupt_request_two <= next_request;
    end
  end

  // Sticky status for the level interrupt.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `IEG_STAT_RESET;
    end else begin
      irq_status <= next_status;
    end
  end

  // [RULE11] Registered core request.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_irq_request <= 8'h00;
    end else begin
      core_irq_request <= gated;
    end
  end

  // The level interrupt looks at the next status, so it rises in the same
  // cycle as the sticky bit rather than one later.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // [RULE1] Enable register, all bits read back.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_enable_two <= `IEG_EN_RESET;
    end else begin
      // [RULE2] Bit one stored only.
      if (wr && hit_en) begin
        interrupt_enable_two <= wdata;
      end
    end
  end

  // Interrupt mask for the level output.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= `IEG_MASK_RESET;
    end else begin
      if (wr && hit_mask) begin
        irq_mask <= wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and refusal are worked out in the setup cycle and
  // registered, so they stand with ready in the first access cycle.
  // An unmapped or unaligned word reads as zero with an error, and a
  // write there changes nothing.
  always @* begin
    next_rdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (setup) begin
      if (hit_req) begin
        next_rdata = word_of(interrupt_request_two);
      end else if (hit_en) begin
        next_rdata = word_of(interrupt_enable_two);
      end else if (hit_stat) begin
        next_rdata = word_of(irq_status);
      end else if (hit_mask) begin
        next_rdata = word_of(irq_mask);
      end else if (hit_pend) begin
        next_rdata = word_of(gated);
      end
      next_slverr = !hit_any;
    end
  end

  // One wait-free access cycle: ready rises in the first access cycle.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Read data, zero except in the cycle after a setup phase, writes included.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_rdata;
    end
  end

  // Error response, high only beside ready.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_slverr;
    end
  end

endmodule // ieg_top

// ==== verification/ieg_core_model.sv ====
// Behavioural model of the core accepting raised sources.
module ieg_core_model (
  input wire sys_clk, rst_n, irq,
  input wire [7:0] core_irq_request,
  output reg [7:0] taken
);
  timeunit 1ns / 1ps;
  // The core only latches sources while the level line is up.
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n) taken <= 8'h00;
    else if (irq) taken <= taken | core_irq_request;
endmodule // ieg_core_model

// ==== verification/ieg_props.sv ====
// Port checker for the interrupt enable group, bound to its top.
module ieg_checker (
  input wire sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire [7:0] core_irq_request
);
  timeunit 1ns / 1ps;
  wire we = psel & penable & pready & pwrite & (paddr == 12'h3FC);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_fix; (core_irq_request & 8'h82) == 8'h00; endproperty
  a_fix: assert property (p_fix) else $error("fixed bit high");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_err; pready && paddr == 12'h7F0 |-> pslverr && !prdata; endproperty
  a_err: assert property (p_err) else $error("bad refusal");
  property p_hi; pready |-> prdata[31:8] == 24'h00_0000; endproperty
  a_hi: assert property (p_hi) else $error("upper data set");
  property p_en0; we && !pwdata[0] |=> ##1 !core_irq_request[0]; endproperty
  a_en0: assert property (p_en0) else $error("pin a ungated");
  property p_en2; we && !pwdata[2] |=> ##1 !core_irq_request[2]; endproperty
  a_en2: assert property (p_en2) else $error("serial ungated");
  property p_en6; we && !pwdata[6] |=> ##1 !core_irq_request[6]; endproperty
  a_en6: assert property (p_en6) else $error("timer ungated");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_tim: cover property (core_irq_request[6]);
endmodule // ieg_checker
bind ieg_top ieg_checker chk (.*);

// ==== verification/tb.sv ====
// Self-checking bench for the interrupt enable group.
module tb;
  timeunit 1ns / 1ps;
  reg sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  reg ext_irq_pin_a = 0, ext_irq_pin_b = 0, serial_event = 0;
  reg twowire_event = 0, timer5_overflow = 0, timer6_overflow = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [7:0] core_irq_request, taken;
  reg [9:0] q[$];
  reg [7:0] v;
  integer seed = 32'h774b_a322, err_total = 0, checks_done = 0, i;
  ieg_top DUT (.*);
  ieg_core_model core (.*);
  initial forever #25 sys_clk = ~sys_clk;
  task automatic xfer(input [11:0] a, input w, input [7:0] d);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input [11:0] a, input [9:0] e);
    q.push_back(e);
    xfer(a, 0, 0);
  endtask
  task automatic cmp(input [9:0] e, g);
    checks_done++;
    if (e !== g) begin
      err_total++;
      $display("mismatch read exp %h got %h", e, g);
    end
  endtask
  task automatic cmp_core(input [7:0] e, g);
    checks_done++;
    if (e !== g) begin
      err_total++;
      $display("mismatch core exp %h got %h", e, g);
    end
  endtask
  task automatic pulse(input [5:0] p);
    {ext_irq_pin_a, ext_irq_pin_b, serial_event, twowire_event,
      timer5_overflow, timer6_overflow} <= p;
    @(posedge sys_clk);
    {serial_event, twowire_event, timer5_overflow, timer6_overflow} <= 0;
    repeat (8) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp(q.pop_front(), {pslverr, irq, prdata[7:0]});
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #(50 * 6000);
    err_total++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    rd(12'h3FC, 0);
    rd(12'h3F4, 0);
    for (i = 0; i < 4; i++) begin
      v = $random(seed) & 8'hFD;
      xfer(12'h3FC, 1, v);
      rd(12'h3FC, {2'b00, v});
    end
    $display("test enable done");
    xfer(12'h3FC, 1, 8'h7D);
    pulse(6'h01);
    rd(12'h3F4, 0);
    pulse(6'h3E);
    rd(12'h3F4, 10'h075);
    rd(12'h408, 10'h075);
    xfer(12'h404, 1, 8'hFF);
    rd(12'h404, 10'h1FF);
    xfer(12'h400, 1, 8'hFF);
    rd(12'h400, 0);
    xfer(12'h3FC, 1, 8'h01);
    rd(12'h408, 10'h001);
    xfer(12'h3F4, 1, 8'hFB);
    rd(12'h3F4, 10'h071);
    rd(12'h7F0, 10'h200);
    $display("test events done");
    xfer(12'h3FC, 1, 8'h08);
    repeat (4100) @(posedge sys_clk);
    rd(12'h408, 10'h108);
    cmp_core(8'h08, core_irq_request);
    cmp_core(8'h7D, taken);
    $display("test tick done");
    report_and_stop;
  end
endmodule // tb
